// [cstr_regs.svh]
// Constants for the CPU status and trap-save register block.
// Assumes inclusion by the design modules; cstr_pkg.sv does not include it.
`ifndef CSTR_REGS_SVH
`define CSTR_REGS_SVH

// System register numbers
`define CSTR_SR_STATUS      5'h05
`define CSTR_SR_TC_PC       5'h10
`define CSTR_SR_TC_STATUS   5'h11
`define CSTR_SR_TRAP_PC     5'h12
`define CSTR_SR_TRAP_STATUS 5'h13
`define CSTR_SR_TC_BASE     5'h14
`define CSTR_SR_DEBUG_IND   5'h15

// Status word field positions, width and reset value
`define CSTR_SW_Z   0
`define CSTR_SW_S   1
`define CSTR_SW_OVF   2
`define CSTR_SW_CARRY 3
`define CSTR_SW_SAT 4
`define CSTR_SW_W   8
`define CSTR_SW_RST 8'h20

// Program counter width, saturation limits and word step
`define CSTR_PC_W      26
`define CSTR_SAT_MAX   32'h7FFFFFFF
`define CSTR_SAT_MIN   32'h80000000
`define CSTR_WORD_STEP 32'h00000004

`endif

// [cstr_pkg.sv]
// Types shared by the status and trap-save block.
// Assumes cstr_regs.svh is on the include path.
package cstr_pkg;
    typedef enum logic [2:0] {
        ALU_ADD, ALU_SUB, ALU_SATADD, ALU_SATSUB, ALU_LOGIC
    } cstr_aluop_e;
    typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} cstr_size_e;
    typedef enum logic [1:0] {BIT_SET, BIT_CLR, BIT_NOT, BIT_TST} cstr_bitop_e;
    typedef struct packed {
        cstr_aluop_e op;
        logic [31:0] a;
        logic [31:0] b;
    } cstr_alu_req_s;
    typedef struct packed {
        logic [31:0] addr;
        cstr_size_e  size;
    } cstr_mem_req_s;
endpackage

// [cstr_align.sv]
// Splits word and halfword accesses into 32-bit bus cycles.
// Assumes a bus that takes a cycle when busValid and busReady are high.
`timescale 1ns/1ps
`include "cstr_regs.svh"
module cstr_align (
    input  wire logic                   core_clk,
    input  wire logic                   nrst,
    input  wire logic                   req,
    input  wire cstr_pkg::cstr_mem_req_s memReq,
    input  wire logic                   misalignEn,
    input  wire logic                   busReady,
    output logic                        reqReady,
    output logic                        busValid,
    output logic [31:0]                 busAddr,
    output logic [3:0]                  busBe,
    output logic                        busLast,
    output logic                        alignErr
);
    logic [3:0]  mask;
    logic [6:0]  span;
    logic        misaligned;
    logic        pend;
    logic [3:0]  pendBe;
    logic [31:0] pendAddr;

    // Little-endian lanes: byte 0 on bits 7:0
    always_comb begin
        unique case (memReq.size)
            cstr_pkg::SZ_BYTE: mask = 4'h1;
            cstr_pkg::SZ_HALF: mask = 4'h3;
            default:           mask = 4'hF;
        endcase
    end
    assign span = {3'h0, mask} << memReq.addr[1:0];
    assign misaligned =
        (memReq.size == cstr_pkg::SZ_HALF && memReq.addr[0]) ||
        (memReq.size == cstr_pkg::SZ_WORD && |memReq.addr[1:0]);
    assign reqReady = !pend && (!busValid || busReady);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            busValid <= 1'b0;
            busAddr  <= 32'h0000_0000;
            busBe    <= 4'h0;
            busLast  <= 1'b0;
            pend     <= 1'b0;
            pendBe   <= 4'h0;
            pendAddr <= 32'h0000_0000;
            alignErr <= 1'b0;
        end else begin
            alignErr <= 1'b0;
            if (req && reqReady) begin
                if (misaligned && !misalignEn) begin
                    // Refused outright rather than silently rounded
                    alignErr <= 1'b1;
                    busValid <= 1'b0;
                end else begin
                    busValid <= 1'b1;
                    busAddr  <= {memReq.addr[31:2], 2'h0};
                    busBe    <= span[3:0];
                    busLast  <= (span[6:4] == 3'h0);
                    pend     <= (span[6:4] != 3'h0);
                    pendBe   <= {1'h0, span[6:4]};
                    pendAddr <= {memReq.addr[31:2], 2'h0} + `CSTR_WORD_STEP;
                end
            end else if (pend && busReady) begin
                busValid <= 1'b1;
                busAddr  <= pendAddr;
                busBe    <= pendBe;
                busLast  <= 1'b1;
                pend     <= 1'b0;
            end else if (busReady) begin
                busValid <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    chk_misalign_refused: assert property (
        req && reqReady && misaligned && !misalignEn
        |=> alignErr && !busValid)
        else $error("misaligned access not refused");
    chk_extra_bus_cycle: assert property (
        busValid && !busLast && busReady |=> busValid && busLast)
        else $error("second bus cycle missing");
    cov_split_access: cover property (busValid && !busLast ##1 busLast);
endmodule // cstr_align

// [cstr_core.sv]
// CPU status word, table-call and trap save registers, debug indicator.
// Assumes the pipeline gives one-cycle event pulses on core_clk.
`timescale 1ns/1ps
`include "cstr_regs.svh"
module cstr_core (
    input  wire logic                    core_clk,
    input  wire logic                    nrst,
    input  wire logic                    aluValid,
    input  wire cstr_pkg::cstr_alu_req_s aluReq,
    output logic [31:0]                  aluResult,
    output logic                         aluDone,
    input  wire logic                    instRetire,
    input  wire logic [2:0]              instLen,
    input  wire logic                    pcLoad,
    input  wire logic [31:0]             pcLoadAddr,
    output logic [31:0]                  programCounter,
    input  wire logic                    tableCall,
    input  wire logic                    excTrap,
    input  wire logic                    dbgTrap,
    input  wire logic                    dbgReturn,
    input  wire logic                    sysWrite,
    input  wire logic                    sysRead,
    input  wire logic [4:0]              sysRegNum,
    input  wire logic [31:0]             sysWrData,
    output logic [31:0]                  sysRdData,
    output logic                         sysRdValid,
    output logic [31:0]                  tableCallBase,
    output logic [7:0]                   statusWord,
    output logic                         debugModeBit,
    input  wire logic                    bitReq,
    input  wire cstr_pkg::cstr_bitop_e   bitOp,
    input  wire logic [2:0]              bitNum,
    input  wire logic [7:0]              bitByteIn,
    output logic [7:0]                   bitByteOut,
    output logic                         bitByteWrite,
    input  wire logic                    ldValid,
    input  wire logic [31:0]             ldWord,
    input  wire cstr_pkg::cstr_mem_req_s ldReq,
    input  wire logic                    ldSigned,
    output logic [31:0]                  ldData,
    output logic                         ldDone,
    input  wire logic                    memReqValid,
    input  wire cstr_pkg::cstr_mem_req_s memReq,
    input  wire logic                    misalignEn,
    input  wire logic                    busReady,
    output logic                         memReqReady,
    output logic                         busValid,
    output logic [31:0]                  busAddr,
    output logic [3:0]                   busBe,
    output logic                         busLast,
    output logic                         alignErr
);
    localparam int PW = `CSTR_PC_W;

    logic [32:0]     sum;
    logic [31:0]     rawRes;
    logic            ovf;
    logic            isSat;
    logic [31:0]     next_res;
    logic [7:0]      next_sw;
    logic [PW-1:0]   nextPc;
    logic [PW-1:0]   pc;
    logic [PW-1:0]   tcPc;
    logic [PW-1:0]   trapPc;
    logic [7:0]      tcSw;
    logic [7:0]      trapSw;
    logic [PW-1:0]   tcBase;
    logic            dbgMode;
    logic            trapEv;
    logic            bitCur;
    logic [7:0]      next_byte;
    logic [31:0]     laneWord;
    logic [31:0]     next_ld;

    assign trapEv = excTrap || dbgTrap;

    // Two's complement add and subtract; bit 32 is carry or borrow
    always_comb begin
        if (aluReq.op == cstr_pkg::ALU_SUB || aluReq.op == cstr_pkg::ALU_SATSUB)
            sum = {1'b0, aluReq.a} - {1'b0, aluReq.b};
        else
            sum = {1'b0, aluReq.a} + {1'b0, aluReq.b};
    end
    assign rawRes = (aluReq.op == cstr_pkg::ALU_LOGIC) ? aluReq.a
                                                       : sum[31:0];
    assign isSat = (aluReq.op == cstr_pkg::ALU_SATADD) ||
                   (aluReq.op == cstr_pkg::ALU_SATSUB);
    always_comb begin
        unique case (aluReq.op)
            cstr_pkg::ALU_ADD, cstr_pkg::ALU_SATADD:
                ovf = (aluReq.a[31] == aluReq.b[31]) &&
                      (sum[31] != aluReq.a[31]);
            cstr_pkg::ALU_SUB, cstr_pkg::ALU_SATSUB:
                ovf = (aluReq.a[31] != aluReq.b[31]) &&
                      (sum[31] != aluReq.a[31]);
            default: ovf = 1'b0;
        endcase
    end

    // Flag and result update
    always_comb begin
        next_sw  = statusWord;
        next_res = rawRes;
        if (isSat && ovf) begin
            // Overflow direction is the sign of the first operand
            next_res = aluReq.a[31] ? `CSTR_SAT_MIN
                                    : `CSTR_SAT_MAX;
            next_sw[`CSTR_SW_SAT] = 1'b1;
            next_sw[`CSTR_SW_OVF] = 1'b1;
        end else begin
            next_sw[`CSTR_SW_OVF] = ovf;
        end
        next_sw[`CSTR_SW_S] = next_res[31];
        next_sw[`CSTR_SW_Z] = (next_res == 32'h0000_0000);
        if (aluReq.op != cstr_pkg::ALU_LOGIC)
            next_sw[`CSTR_SW_CARRY] = sum[32];
    end

    // Next instruction address; carry out of the top bit is lost
    assign nextPc = (pc + PW'(instLen)) & ~PW'(1);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pc <= '0;
        end else if (pcLoad) begin
            pc <= pcLoadAddr[PW-1:0] & ~PW'(1);
        end else if (instRetire) begin
            pc <= nextPc;
        end
    end
    assign programCounter = {{(32-PW){1'b0}}, pc};

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            aluResult <= 32'h0000_0000;
            aluDone   <= 1'b0;
        end else begin
            aluDone <= aluValid;
            if (aluValid)
                aluResult <= next_res;
        end
    end

    // Status word: flag results beat a system register write
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            statusWord <= `CSTR_SW_RST;
        end else if (aluValid) begin
            statusWord <= next_sw;
        end else if (bitReq) begin
            statusWord[`CSTR_SW_Z] <= !bitCur;
        end else if (sysWrite && sysRegNum == `CSTR_SR_STATUS) begin
            statusWord <= sysWrData[`CSTR_SW_W-1:0];
        end
    end

    // Table-call save; the event wins over a concurrent load
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tcPc <= '0;
            tcSw <= 8'h00;
        end else if (tableCall) begin
            tcPc <= nextPc;
            tcSw <= statusWord;
        end else if (sysWrite) begin
            if (sysRegNum == `CSTR_SR_TC_PC)
                tcPc <= sysWrData[PW-1:0];
            if (sysRegNum == `CSTR_SR_TC_STATUS)
                tcSw <= sysWrData[7:0];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            trapPc <= '0;
            trapSw <= 8'h00;
        end else if (trapEv) begin
            trapPc <= nextPc;
            trapSw <= statusWord;
        end else if (sysWrite) begin
            if (sysRegNum == `CSTR_SR_TRAP_PC)
                trapPc <= sysWrData[PW-1:0];
            if (sysRegNum == `CSTR_SR_TRAP_STATUS)
                trapSw <= sysWrData[7:0];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tcBase <= '0;
        end else if (sysWrite && sysRegNum == `CSTR_SR_TC_BASE) begin
            tcBase <= sysWrData[PW-1:0] & ~PW'(1);
        end
    end
    assign tableCallBase = {{(32-PW){1'b0}}, tcBase};

    // Set wins over the return so a trap is never lost
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            dbgMode <= 1'b0;
        end else if (trapEv) begin
            dbgMode <= 1'b1;
        end else if (dbgReturn) begin
            dbgMode <= 1'b0;
        end
    end
    assign debugModeBit = dbgMode;

    // Read port; the indicator ignores writes
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sysRdData  <= 32'h0000_0000;
            sysRdValid <= 1'b0;
        end else begin
            sysRdValid <= sysRead;
            if (sysRead) begin
                unique case (sysRegNum)
                    `CSTR_SR_STATUS:
                        sysRdData <= {24'h0, statusWord};
                    `CSTR_SR_TC_PC:
                        sysRdData <= {6'h0, tcPc};
                    `CSTR_SR_TC_STATUS:
                        sysRdData <= {24'h0, tcSw};
                    `CSTR_SR_TRAP_PC:
                        sysRdData <= {6'h0, trapPc};
                    `CSTR_SR_TRAP_STATUS:
                        sysRdData <= {24'h0, trapSw};
                    `CSTR_SR_TC_BASE:
                        sysRdData <= {6'h0, tcBase};
                    `CSTR_SR_DEBUG_IND:
                        sysRdData <= {31'h0, dbgMode};
                    default:
                        sysRdData <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Single-bit operations touch one byte only
    assign bitCur = bitByteIn[bitNum];
    always_comb begin
        next_byte = bitByteIn;
        unique case (bitOp)
            cstr_pkg::BIT_SET: next_byte[bitNum] = 1'b1;
            cstr_pkg::BIT_CLR: next_byte[bitNum] = 1'b0;
            cstr_pkg::BIT_NOT: next_byte[bitNum] = !bitCur;
            cstr_pkg::BIT_TST: next_byte[bitNum] = bitCur;
        endcase
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            bitByteOut   <= 8'h00;
            bitByteWrite <= 1'b0;
        end else begin
            bitByteWrite <= bitReq && bitOp != cstr_pkg::BIT_TST;
            if (bitReq)
                bitByteOut <= next_byte;
        end
    end

    // Load extraction; only aligned-word lanes are handled here
    assign laneWord = ldWord >> {ldReq.addr[1:0], 3'h0};
    always_comb begin
        unique case (ldReq.size)
            cstr_pkg::SZ_BYTE:
                next_ld = {{24{ldSigned && laneWord[7]}},
                           laneWord[7:0]};
            cstr_pkg::SZ_HALF:
                next_ld = {{16{ldSigned && laneWord[15]}},
                           laneWord[15:0]};
            default:
                next_ld = laneWord;
        endcase
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ldData <= 32'h0000_0000;
            ldDone <= 1'b0;
        end else begin
            ldDone <= ldValid;
            if (ldValid)
                ldData <= next_ld;
        end
    end

    cstr_align u_align (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .req        (memReqValid),
        .memReq     (memReq),
        .misalignEn (misalignEn),
        .busReady   (busReady),
        .reqReady   (memReqReady),
        .busValid   (busValid),
        .busAddr    (busAddr),
        .busBe      (busBe),
        .busLast    (busLast),
        .alignErr   (alignErr)
    );

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    chk_sat_positive: assert property (
        aluValid && isSat && ovf && !aluReq.a[31]
        |=> aluResult == `CSTR_SAT_MAX && statusWord[`CSTR_SW_SAT]
            && statusWord[`CSTR_SW_OVF] && !statusWord[`CSTR_SW_S])
        else $error("positive saturation wrong");
    chk_sat_negative: assert property (
        aluValid && isSat && ovf && aluReq.a[31]
        |=> aluResult == `CSTR_SAT_MIN && statusWord[`CSTR_SW_S]
            && statusWord[`CSTR_SW_OVF])
        else $error("negative saturation wrong");
    chk_sat_hold: assert property (
        aluValid && isSat && !ovf
        |=> statusWord[`CSTR_SW_SAT] == $past(statusWord[`CSTR_SW_SAT])
            && !statusWord[`CSTR_SW_OVF])
        else $error("in-range saturate flags wrong");
    chk_sign_zero: assert property (
        aluDone |-> statusWord[`CSTR_SW_S] == aluResult[31]
            && statusWord[`CSTR_SW_Z] == (aluResult == 32'h0))
        else $error("sign or zero flag mismatch");
    chk_tc_save: assert property (
        tableCall && !pcLoad ##1 sysRead
            && sysRegNum == `CSTR_SR_TC_PC && !tableCall && !sysWrite
        |=> sysRdData == {6'h0, $past(nextPc, 2)})
        else $error("table-call PC not next address");
    chk_trap_save: assert property (
        trapEv |=> trapSw == $past(statusWord) && trapPc == $past(nextPc))
        else $error("trap save wrong");
    chk_debug_set: assert property (
        trapEv |=> dbgMode)
        else $error("debug bit not set by trap");
    chk_debug_clear: assert property (
        dbgReturn && !trapEv |=> !dbgMode)
        else $error("debug bit not cleared by return");
    chk_debug_ind_read: assert property (
        sysRdValid && $past(sysRegNum) == `CSTR_SR_DEBUG_IND
        |-> sysRdData[31:1] == 31'h0 && sysRdData[0] == $past(dbgMode))
        else $error("debug indicator read wrong");
    chk_pc_bits: assert property (
        programCounter[31:PW] == '0 && !programCounter[0]
        && tableCallBase[31:PW] == '0 && !tableCallBase[0])
        else $error("fixed address bits not zero");

    cov_sat_pos: cover property (aluValid && isSat && ovf);
    cov_table_call: cover property (tableCall);
    cov_debug_round: cover property (dbgTrap ##[1:20] dbgReturn);
endmodule // cstr_core

// [cstr_bus_model.sv]
// Bus responder standing on the far side of the core's data bus.
// Assumes busValid holds until busReady is seen at a rising edge.
`timescale 1ns/1ps
module cstr_bus_model (
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic       busValid,
    input  wire logic [1:0] stall,
    output logic            busReady
);
    logic [1:0] waitCnt;

    // Wait restarts per cycle, so each half of a split access stalls
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            waitCnt <= 2'h0;
        end else if (!busValid || busReady) begin
            waitCnt <= 2'h0;
        end else begin
            waitCnt <= waitCnt + 2'h1;
        end
    end
    assign busReady = busValid && (waitCnt >= stall);
endmodule // cstr_bus_model

// [cstr_core_test.sv]
// Self-checking bench for the status and trap-save core.
// Assumes cstr_regs.svh on the include path and the bus model beside it.
`timescale 1ns/1ps
module cstr_core_test;
    logic core_clk = 1'b0, nrst = 1'b0, aluValid = 1'b0, aluDone, pcLoad = 1'b0;
    logic instRetire = 1'b0, tableCall = 1'b0, excTrap = 1'b0, dbgTrap = 1'b0;
    logic dbgReturn = 1'b0, sysWrite = 1'b0, sysRead = 1'b0, sysRdValid;
    logic bitReq = 1'b0, bitByteWrite, ldValid = 1'b0, ldSigned = 1'b1, ldDone;
    logic memReqValid = 1'b0, misalignEn = 1'b0, busReady, memReqReady;
    logic busValid, busLast, alignErr, debugModeBit;
    logic [2:0] instLen = 3'h0, bitNum = 3'h3;
    logic [4:0] sysRegNum = 5'h00;
    logic [7:0] statusWord, bitByteIn = 8'h00, bitByteOut;
    logic [3:0] busBe;
    logic [31:0] aluResult, pcLoadAddr = 32'h0, programCounter;
    logic [31:0] sysWrData = 32'h0, sysRdData, tableCallBase, ldData, busAddr;
    logic [31:0] ldWord = 32'h80FF0000;
    cstr_pkg::cstr_alu_req_s aluReq = '0;
    cstr_pkg::cstr_bitop_e   bitOp = cstr_pkg::BIT_SET;
    cstr_pkg::cstr_mem_req_s ldReq = '{32'h2, cstr_pkg::SZ_HALF};
    cstr_pkg::cstr_mem_req_s memReq = '0;
    logic [36:0] seen[$];
    int fails = 0, total_checks = 0;

    cstr_core u_dut (.core_clk(core_clk), .nrst(nrst), .aluValid(aluValid),
        .aluReq(aluReq), .aluResult(aluResult), .aluDone(aluDone),
        .instRetire(instRetire), .instLen(instLen), .pcLoad(pcLoad),
        .pcLoadAddr(pcLoadAddr), .programCounter(programCounter),
        .tableCall(tableCall), .excTrap(excTrap), .dbgTrap(dbgTrap),
        .dbgReturn(dbgReturn), .sysWrite(sysWrite), .sysRead(sysRead),
        .sysRegNum(sysRegNum), .sysWrData(sysWrData), .sysRdData(sysRdData),
        .sysRdValid(sysRdValid), .tableCallBase(tableCallBase),
        .statusWord(statusWord), .debugModeBit(debugModeBit), .bitReq(bitReq),
        .bitOp(bitOp), .bitNum(bitNum), .bitByteIn(bitByteIn),
        .bitByteOut(bitByteOut), .bitByteWrite(bitByteWrite),
        .ldValid(ldValid), .ldWord(ldWord), .ldReq(ldReq), .ldSigned(ldSigned),
        .ldData(ldData), .ldDone(ldDone), .memReqValid(memReqValid),
        .memReq(memReq), .misalignEn(misalignEn), .busReady(busReady),
        .memReqReady(memReqReady), .busValid(busValid), .busAddr(busAddr),
        .busBe(busBe), .busLast(busLast), .alignErr(alignErr));
    cstr_bus_model u_bus (.core_clk(core_clk), .nrst(nrst),
        .busValid(busValid), .stall(2'h1), .busReady(busReady));

    always #2 core_clk = ~core_clk;
    always @(posedge core_clk)
        if (busValid && busReady)
            seen.push_back({busAddr, busBe, busLast});

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [36:0] got, input logic [36:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step(); @(negedge core_clk); endtask
    // Trailing idle cycle so a following call never re-raises a strobe
    task automatic alu(input cstr_pkg::cstr_aluop_e op, input logic [31:0] a,
        input logic [31:0] b, input logic [31:0] res, input logic [7:0] sw);
        aluValid = 1'b1;
        aluReq = '{op, a, b};
        step();
        aluValid = 1'b0;
        chk({aluDone, aluResult}, {1'b1, res});
        chk(statusWord, sw);
        step();
    endtask
    task automatic sys_wr(input logic [4:0] n, input logic [31:0] d);
        sysWrite = 1'b1;
        sysRegNum = n;
        sysWrData = d;
        step();
        sysWrite = 1'b0;
        step();
    endtask
    task automatic sys_rd(input logic [4:0] n, input logic [31:0] exp);
        sysRead = 1'b1;
        sysRegNum = n;
        step();
        sysRead = 1'b0;
        chk({sysRdValid, sysRdData}, {1'b1, exp});
        step();
    endtask
    task automatic bit_op(input cstr_pkg::cstr_bitop_e op,
        input logic [7:0] in, input logic [9:0] exp);
        bitReq = 1'b1;
        bitOp = op;
        bitByteIn = in;
        step();
        bitReq = 1'b0;
        chk({bitByteWrite, bitByteOut, statusWord[0]}, exp);
        step();
    endtask
    task automatic mem_req(input logic [31:0] addr,
        input cstr_pkg::cstr_size_e sz);
        memReqValid = 1'b1;
        memReq = '{addr, sz};
        step();
        memReqValid = 1'b0;
    endtask

    task automatic test_alu();
        alu(cstr_pkg::ALU_ADD, 32'h80000000, 32'h00000001,
            32'h80000001, 8'h22);
        alu(cstr_pkg::ALU_ADD, 32'hFFFFFFFF, 32'h00000001,
            32'h0, 8'h29);
        alu(cstr_pkg::ALU_SUB, 32'h00000000, 32'h00000001,
            32'hFFFFFFFF, 8'h2A);
        alu(cstr_pkg::ALU_SUB, 32'h5, 32'h5, 32'h0, 8'h21);
        alu(cstr_pkg::ALU_SATADD, 32'h7FFFFFFF, 32'h1,
            32'h7FFFFFFF, 8'h34);
        alu(cstr_pkg::ALU_SATADD, 32'h1, 32'h1, 32'h2, 8'h30);
        alu(cstr_pkg::ALU_SATSUB, 32'h80000000, 32'h1,
            32'h80000000, 8'h36);
        $display("test_alu done");
    endtask
    task automatic test_saves();
        sys_wr(5'h05, 32'hFFFFFF25);
        pcLoad = 1'b1;
        pcLoadAddr = 32'hFC000101;
        step();
        pcLoad = 1'b0;
        chk(programCounter, 32'h100);
        tableCall = 1'b1;
        instLen = 3'h4;
        step();
        tableCall = 1'b0;
        sys_rd(5'h10, 32'h104);
        sys_rd(5'h11, 32'h25);
        pcLoad = 1'b1;
        pcLoadAddr = 32'h03FFFFFC;
        step();
        pcLoad = 1'b0;
        instRetire = 1'b1;
        instLen = 3'h2;
        step();
        instRetire = 1'b0;
        excTrap = 1'b1;
        instLen = 3'h4;
        step();
        excTrap = 1'b0;
        sys_rd(5'h12, 32'h2);
        sys_rd(5'h13, 32'h25);
        sys_wr(5'h15, 32'h0);
        sys_rd(5'h15, 32'h1);
        dbgReturn = 1'b1;
        step();
        dbgReturn = 1'b0;
        step();
        chk(debugModeBit, 1'b0);
        dbgTrap = 1'b1;
        step();
        dbgTrap = 1'b0;
        step();
        chk(debugModeBit, 1'b1);
        sys_wr(5'h14, 32'hFFFFFFFF);
        sys_rd(5'h14, 32'h03FFFFFE);
        chk(tableCallBase, 32'h03FFFFFE);
        sys_rd(5'h06, 32'h0);
        $display("test_saves done");
    endtask
    // Mid-run reset with debug bit, base and status word away from reset
    task automatic test_reset();
        nrst = 1'b0;
        step();
        chk({debugModeBit, tableCallBase}, 33'h0);
        chk({memReqReady, statusWord}, 9'h120);
        nrst = 1'b1;
        step();
        $display("test_reset done");
    endtask
    task automatic test_data();
        bit_op(cstr_pkg::BIT_SET, 8'h00, {1'b1, 8'h08, 1'b1});
        bit_op(cstr_pkg::BIT_CLR, 8'h0C, {1'b1, 8'h04, 1'b0});
        bit_op(cstr_pkg::BIT_NOT, 8'h04, {1'b1, 8'h0C, 1'b1});
        bit_op(cstr_pkg::BIT_TST, 8'h0C, {1'b0, 8'h0C, 1'b0});
        ldValid = 1'b1;
        step();
        ldValid = 1'b0;
        chk({ldDone, ldData}, {1'b1, 32'hFFFF80FF});
        mem_req(32'h2, cstr_pkg::SZ_WORD);
        chk({alignErr, busValid}, 2'h2);
        step();
        mem_req(32'h1, cstr_pkg::SZ_HALF);
        chk({alignErr, busValid}, 2'h2);
        step();
        misalignEn = 1'b1;
        mem_req(32'h3, cstr_pkg::SZ_WORD);
        repeat (8) step();
        chk(seen.size(), 2);
        chk(seen[0], {32'h0, 4'h8, 1'b0});
        chk(seen[1], {32'h4, 4'h7, 1'b1});
        $display("test_data done");
    endtask

    initial begin
        repeat (8) step();
        nrst = 1'b1;
        step();
        chk(statusWord, 8'h20);
        test_alu();
        test_saves();
        test_reset();
        test_data();
        end_sim();
    end
    initial begin
        #20000;
        fails++;
        end_sim();
    end
endmodule // cstr_core_test
